//--- src/clcb_top.sv
// Functional notes
// - Both overcurrent warn thresholds take 0 to 127 A in 0.5 A steps, input default 5 A.
// - Overtemperature fault and warn thresholds take 0 to 150 degrees, defaults 125 and 105.
// - With OT action F9h the output stays off while the fault lasts and returns after.
// - With OT action F9h restart is retried without limit until turned off or another fault.
// - The OT action register holds only 00h,16h,22h,36h,C0h,D6h,E2h,F6h or F9h.
// - Input OV fault and UV warn thresholds take 1 to 80 V in 0.5 V steps, defaults 15/9 V.
// - With input OV action B8h the output is off while the fault lasts and restarts once it clears.
// - The input OV action register holds only 00h,16h,22h,36h,B8h,C0h,D6h,E2h or F6h.
// - Power-good levels take 0.24 to 14 V in LINEAR16, defaults 0.54 V and 0.51 V.
// - Turn-on wait and ramp take 0 to 127 ms in 1 ms LINEAR11 steps, defaults 0 and 5 ms.
`timescale 1ns/100ps
module clcb_top
  import clcb_pkg::*;
#(
  parameter logic [15:0] IOUT_OCW_DEF = RST_IOUT_OCW,
  parameter int          MS_CNT       = MS_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        cmd_wr,
  input  wire logic        cmd_rd,
  input  wire logic [7:0]  cmd_addr,
  input  wire logic [15:0] cmd_wdata,
  input  wire logic        on_req,
  input  wire logic        other_fault,
  input  wire logic [10:0] iout_meas,
  input  wire logic [10:0] iin_meas,
  input  wire logic [10:0] temp_meas,
  input  wire logic [10:0] vin_meas,
  input  wire logic [15:0] vout_sense,
  output logic [15:0]      cmd_rdata,
  output logic             cmd_ack,
  output logic             cmd_nack,
  output logic             out_en,
  output logic             pgood,
  output logic [3:0]       warn_stat,
  output logic             ot_flt_stat,
  output logic             vin_flt_stat
);
  import clcb_pkg::*;

  typedef struct packed {
    logic [15:0] iout_ocw;
    logic [15:0] ot_flt;
    logic [7:0]  ot_act;
    logic [15:0] ot_wrn;
    logic [15:0] vin_ovf;
    logic [7:0]  vin_act;
    logic [15:0] vin_uvw;
    logic [15:0] iin_ocw;
    logic [15:0] pg_on;
    logic [15:0] pg_off;
    logic [15:0] ton_wait;
    logic [15:0] ton_ramp;
    logic [15:0] rdata;
    logic        ack;
    logic        nack;
    logic        out_en;
    logic        pgood;
    logic [3:0]  warn;
    logic        ot_flt_s;
    logic        vin_flt_s;
  } clcb_top_s;

  clcb_top_s st_ff;
  clcb_top_s nxt_st;
  clcb_cfg_if cfg ();

  logic       seq_en;
  logic       pg_raw;
  logic       ot_fault;
  logic       vin_fault;
  logic [3:0] warn_now;
  logic       wr_ok;
  logic [15:0] rd_val;
  logic       rd_hit;

  function automatic logic half_ok(input logic [15:0] v, input logic [10:0] lo,
                                   input logic [10:0] hi);
    half_ok = (v[15:11] == EXP_HALF) && (v[10:0] >= lo) && (v[10:0] <= hi);
  endfunction : half_ok

  function automatic logic unit_ok(input logic [15:0] v, input logic [10:0] hi);
    unit_ok = (v[15:11] == EXP_UNIT) && (v[10:0] <= hi);
  endfunction : unit_ok

  function automatic logic ot_code_ok(input logic [7:0] c);
    case (c)
      8'h00, 8'h16, 8'h22, 8'h36, 8'hC0, 8'hD6, 8'hE2, 8'hF6, 8'hF9: ot_code_ok = 1'b1;
      default: ot_code_ok = 1'b0;
    endcase
  endfunction : ot_code_ok

  function automatic logic vin_code_ok(input logic [7:0] c);
    case (c)
      8'h00, 8'h16, 8'h22, 8'h36, 8'hB8, 8'hC0, 8'hD6, 8'hE2, 8'hF6: vin_code_ok = 1'b1;
      default: vin_code_ok = 1'b0;
    endcase
  endfunction : vin_code_ok

  // Fault and warn compares in native measurement units
  assign ot_fault  = (temp_meas >= st_ff.ot_flt[10:0]);
  assign vin_fault = ({vin_meas} >= st_ff.vin_ovf[10:0]);
  assign warn_now[WB_IOUT]   = (iout_meas >= st_ff.iout_ocw[10:0]);
  assign warn_now[WB_IIN]    = (iin_meas >= st_ff.iin_ocw[10:0]);
  assign warn_now[WB_OT]     = (temp_meas >= st_ff.ot_wrn[10:0]);
  assign warn_now[WB_VIN_UV] = (vin_meas < st_ff.vin_uvw[10:0]);

  assign cfg.ot_act  = st_ff.ot_act;
  assign cfg.vin_act = st_ff.vin_act;
  assign cfg.wait_ms = st_ff.ton_wait;
  assign cfg.ramp_ms = st_ff.ton_ramp;

  // Out-of-range writes are refused and leave the register untouched
  always_comb begin
    wr_ok = 1'b0;
    case (cmd_addr)
      ADDR_IOUT_OCW: wr_ok = half_ok(cmd_wdata, 11'h000, MAX_HALF_AMP);
      ADDR_IIN_OCW:  wr_ok = half_ok(cmd_wdata, 11'h000, MAX_HALF_AMP);
      ADDR_OT_FLT:   wr_ok = unit_ok(cmd_wdata, MAX_DEG);
      ADDR_OT_WRN:   wr_ok = unit_ok(cmd_wdata, MAX_DEG);
      ADDR_OT_ACT:   wr_ok = ot_code_ok(cmd_wdata[7:0]);
      ADDR_VIN_ACT:  wr_ok = vin_code_ok(cmd_wdata[7:0]);
      ADDR_VIN_OVF:  wr_ok = half_ok(cmd_wdata, MIN_HALF_VOLT, MAX_HALF_VOLT);
      ADDR_VIN_UVW:  wr_ok = half_ok(cmd_wdata, MIN_HALF_VOLT, MAX_HALF_VOLT);
      ADDR_PG_ON:    wr_ok = (cmd_wdata >= MIN_PG) && (cmd_wdata <= MAX_PG);
      ADDR_PG_OFF:   wr_ok = (cmd_wdata >= MIN_PG) && (cmd_wdata <= MAX_PG);
      ADDR_TON_WAIT: wr_ok = unit_ok(cmd_wdata, MAX_MS);
      ADDR_TON_RAMP: wr_ok = unit_ok(cmd_wdata, MAX_MS);
      default:       wr_ok = 1'b0;
    endcase
  end

  always_comb begin
    rd_hit = 1'b1;
    case (cmd_addr)
      ADDR_IOUT_OCW: rd_val = st_ff.iout_ocw;
      ADDR_OT_FLT:   rd_val = st_ff.ot_flt;
      ADDR_OT_ACT:   rd_val = {8'h00, st_ff.ot_act};
      ADDR_OT_WRN:   rd_val = st_ff.ot_wrn;
      ADDR_VIN_OVF:  rd_val = st_ff.vin_ovf;
      ADDR_VIN_ACT:  rd_val = {8'h00, st_ff.vin_act};
      ADDR_VIN_UVW:  rd_val = st_ff.vin_uvw;
      ADDR_IIN_OCW:  rd_val = st_ff.iin_ocw;
      ADDR_PG_ON:    rd_val = st_ff.pg_on;
      ADDR_PG_OFF:   rd_val = st_ff.pg_off;
      ADDR_TON_WAIT: rd_val = st_ff.ton_wait;
      ADDR_TON_RAMP: rd_val = st_ff.ton_ramp;
      default: begin
        rd_val = 16'h0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.ack  = 1'b0;
    nxt_st.nack = 1'b0;
    if (cmd_wr) begin
      if (wr_ok) begin
        nxt_st.ack = 1'b1;
        case (cmd_addr)
          ADDR_IOUT_OCW: nxt_st.iout_ocw = cmd_wdata;
          ADDR_OT_FLT:   nxt_st.ot_flt   = cmd_wdata;
          ADDR_OT_ACT:   nxt_st.ot_act   = cmd_wdata[7:0];
          ADDR_OT_WRN:   nxt_st.ot_wrn   = cmd_wdata;
          ADDR_VIN_OVF:  nxt_st.vin_ovf  = cmd_wdata;
          ADDR_VIN_ACT:  nxt_st.vin_act  = cmd_wdata[7:0];
          ADDR_VIN_UVW:  nxt_st.vin_uvw  = cmd_wdata;
          ADDR_IIN_OCW:  nxt_st.iin_ocw  = cmd_wdata;
          ADDR_PG_ON:    nxt_st.pg_on    = cmd_wdata;
          ADDR_PG_OFF:   nxt_st.pg_off   = cmd_wdata;
          ADDR_TON_WAIT: nxt_st.ton_wait = cmd_wdata;
          ADDR_TON_RAMP: nxt_st.ton_ramp = cmd_wdata;
          default:       nxt_st.ack      = 1'b0;
        endcase
      end else begin
        nxt_st.nack = 1'b1;
      end
    end else if (cmd_rd) begin
      nxt_st.rdata = rd_val;
      nxt_st.ack   = rd_hit;
      nxt_st.nack  = !rd_hit;
    end
    nxt_st.out_en    = seq_en;
    nxt_st.pgood     = pg_raw;
    nxt_st.warn      = warn_now;
    nxt_st.ot_flt_s  = ot_fault;
    nxt_st.vin_flt_s = vin_fault;
  end

  // Defaults stand in for the non-volatile load
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_ff          <= '0;
      st_ff.iout_ocw <= IOUT_OCW_DEF;
      st_ff.ot_flt   <= RST_OT_FLT;
      st_ff.ot_act   <= RST_OT_ACT;
      st_ff.ot_wrn   <= RST_OT_WRN;
      st_ff.vin_ovf  <= RST_VIN_OVF;
      st_ff.vin_act  <= RST_VIN_ACT;
      st_ff.vin_uvw  <= RST_VIN_UVW;
      st_ff.iin_ocw  <= RST_IIN_OCW;
      st_ff.pg_on    <= RST_PG_ON;
      st_ff.pg_off   <= RST_PG_OFF;
      st_ff.ton_wait <= RST_TON_WAIT;
      st_ff.ton_ramp <= RST_TON_RAMP;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  clcb_seq #(
    .MS_CNT (MS_CNT)
  ) u_seq (
    .mclk        (mclk),
    .rst_n       (rst_n),
    .ce          (ce),
    .on_req      (on_req),
    .ot_fault    (ot_fault),
    .vin_fault   (vin_fault),
    .other_fault (other_fault),
    .cfg         (cfg.ctrl),
    .out_en      (seq_en),
    .ramping     ()
  );

  clcb_pgood u_pg (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .ce         (ce),
    .vout_sense (vout_sense),
    .on_level   (st_ff.pg_on),
    .off_level  (st_ff.pg_off),
    .pgood      (pg_raw)
  );

  assign cmd_rdata    = st_ff.rdata;
  assign cmd_ack      = st_ff.ack;
  assign cmd_nack     = st_ff.nack;
  assign out_en       = st_ff.out_en;
  assign pgood        = st_ff.pgood;
  assign warn_stat    = st_ff.warn;
  assign ot_flt_stat  = st_ff.ot_flt_s;
  assign vin_flt_stat = st_ff.vin_flt_s;

  property p_ot_code;
    @(posedge mclk) disable iff (!rst_n)
      (ce && cmd_wr && cmd_addr == ADDR_OT_ACT && !ot_code_ok(cmd_wdata[7:0]))
        |=> ($stable(st_ff.ot_act) && cmd_nack);
  endproperty
  a_ot_code: assert property (p_ot_code) else $error("bad OT action code stored");

  property p_vin_code;
    @(posedge mclk) disable iff (!rst_n)
      (ce && cmd_wr && cmd_addr == ADDR_VIN_ACT && !vin_code_ok(cmd_wdata[7:0]))
        |=> ($stable(st_ff.vin_act) && cmd_nack);
  endproperty
  a_vin_code: assert property (p_vin_code) else $error("bad VIN action code stored");

  property p_ot_range;
    @(posedge mclk) disable iff (!rst_n)
      (ce && cmd_wr && cmd_addr == ADDR_OT_FLT && cmd_wdata[10:0] > MAX_DEG)
        |=> $stable(st_ff.ot_flt);
  endproperty
  a_ot_range: assert property (p_ot_range) else $error("OT threshold above range");

  property p_oc_write;
    @(posedge mclk) disable iff (!rst_n)
      (ce && cmd_wr && cmd_addr == ADDR_IIN_OCW && half_ok(cmd_wdata, 11'h000, MAX_HALF_AMP))
        |=> (st_ff.iin_ocw == $past(cmd_wdata) && cmd_ack);
  endproperty
  a_oc_write: assert property (p_oc_write) else $error("valid OC warn write lost");

  property p_vin_range;
    @(posedge mclk) disable iff (!rst_n)
      (ce && cmd_wr && cmd_addr == ADDR_VIN_OVF && cmd_wdata[10:0] < MIN_HALF_VOLT)
        |=> $stable(st_ff.vin_ovf);
  endproperty
  a_vin_range: assert property (p_vin_range) else $error("VIN OV threshold below 1 V");

  property p_pg_range;
    @(posedge mclk) disable iff (!rst_n)
      (ce && cmd_wr && cmd_addr == ADDR_PG_ON && cmd_wdata > MAX_PG) |=> $stable(st_ff.pg_on);
  endproperty
  a_pg_range: assert property (p_pg_range) else $error("pgood level above range");

  property p_ton_range;
    @(posedge mclk) disable iff (!rst_n)
      (ce && cmd_wr && cmd_addr == ADDR_TON_RAMP && cmd_wdata[10:0] > MAX_MS)
        |=> $stable(st_ff.ton_ramp);
  endproperty
  a_ton_range: assert property (p_ton_range) else $error("ramp time above 127 ms");

  property p_warn_only;
    @(posedge mclk) disable iff (!rst_n)
      (ce && warn_now[WB_OT] && !ot_fault) |=> warn_stat[WB_OT];
  endproperty
  a_warn_only: assert property (p_warn_only) else $error("OT warn not reported");

  // Registered input OV flag is high whenever the sequencer's latch is, so no block is left out
  property p_warn_keep;
    @(posedge mclk) disable iff (!rst_n)
      (ce && seq_en && warn_now != 4'h0 && on_req && !other_fault && !ot_fault && !vin_fault
        && !st_ff.vin_flt_s) |=> seq_en;
  endproperty
  a_warn_keep: assert property (p_warn_keep) else $error("warn stopped output");

  property p_ramp_write;
    @(posedge mclk) disable iff (!rst_n)
      (ce && cmd_wr && cmd_addr == ADDR_TON_RAMP && unit_ok(cmd_wdata, MAX_MS))
        |=> (st_ff.ton_ramp == $past(cmd_wdata) && cmd_ack);
  endproperty
  a_ramp_write: assert property (p_ramp_write) else $error("valid ramp write lost");

  property p_rd_back;
    @(posedge mclk) disable iff (!rst_n)
      (ce && cmd_rd && !cmd_wr && cmd_addr == ADDR_OT_FLT)
        |=> (cmd_rdata == $past(st_ff.ot_flt) && cmd_ack);
  endproperty
  a_rd_back: assert property (p_rd_back) else $error("OT threshold read wrong");

  property p_unmapped;
    @(posedge mclk) disable iff (!rst_n)
      (ce && (cmd_wr || cmd_rd) && !rd_hit) |=> (cmd_nack && !cmd_ack);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped command not refused");

  property p_idle_quiet;
    @(posedge mclk) disable iff (!rst_n)
      (ce && !cmd_wr && !cmd_rd) |=> (!cmd_ack && !cmd_nack);
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("answer without command");

  property p_ce_hold;
    @(posedge mclk) disable iff (!rst_n)
      !ce |=> $stable(st_ff);
  endproperty
  a_ce_hold: assert property (p_ce_hold) else $error("state moved with enable low");
endmodule : clcb_top

//--- src/clcb_pkg.sv
package clcb_pkg;
  localparam logic [7:0]  ADDR_IOUT_OCW  = 8'h4A;
  localparam logic [7:0]  ADDR_OT_FLT    = 8'h4F;
  localparam logic [7:0]  ADDR_OT_ACT    = 8'h50;
  localparam logic [7:0]  ADDR_OT_WRN    = 8'h51;
  localparam logic [7:0]  ADDR_VIN_OVF   = 8'h55;
  localparam logic [7:0]  ADDR_VIN_ACT   = 8'h56;
  localparam logic [7:0]  ADDR_VIN_UVW   = 8'h58;
  localparam logic [7:0]  ADDR_IIN_OCW   = 8'h5D;
  localparam logic [7:0]  ADDR_PG_ON     = 8'h5E;
  localparam logic [7:0]  ADDR_PG_OFF    = 8'h5F;
  localparam logic [7:0]  ADDR_TON_WAIT  = 8'h60;
  localparam logic [7:0]  ADDR_TON_RAMP  = 8'h61;
  localparam logic [15:0] RST_IOUT_OCW   = 16'hF868;
  localparam logic [15:0] RST_OT_FLT     = 16'h007D;
  localparam logic [7:0]  RST_OT_ACT     = 8'hF9;
  localparam logic [15:0] RST_OT_WRN     = 16'h0069;
  localparam logic [15:0] RST_VIN_OVF    = 16'hF81E;
  localparam logic [7:0]  RST_VIN_ACT    = 8'hB8;
  localparam logic [15:0] RST_VIN_UVW    = 16'hF812;
  localparam logic [15:0] RST_IIN_OCW    = 16'hF80A;
  localparam logic [15:0] RST_PG_ON      = 16'h0114;
  localparam logic [15:0] RST_PG_OFF     = 16'h0105;
  localparam logic [15:0] RST_TON_WAIT   = 16'h0000;
  localparam logic [15:0] RST_TON_RAMP   = 16'h0005;
  // LINEAR11 mantissa field and fixed exponents
  localparam int          L11_MANT_W     = 11;
  localparam logic [4:0]  EXP_HALF       = 5'h1F;
  localparam logic [4:0]  EXP_UNIT       = 5'h00;
  localparam logic [10:0] MAX_HALF_AMP   = 11'h0FE;
  localparam logic [10:0] MAX_DEG        = 11'h096;
  localparam logic [10:0] MIN_HALF_VOLT  = 11'h002;
  localparam logic [10:0] MAX_HALF_VOLT  = 11'h0A0;
  localparam logic [10:0] MAX_MS         = 11'h07F;
  localparam logic [15:0] MIN_PG         = 16'h007B;
  localparam logic [15:0] MAX_PG         = 16'h1C00;
  localparam logic [7:0]  ACT_OT_RETRY   = 8'hF9;
  localparam logic [7:0]  ACT_VIN_LATCH  = 8'hB8;
  localparam logic [7:0]  ACT_IGNORE     = 8'h00;
  localparam real         CLK_MHZ        = 25.0;
  localparam real         MS_TIME        = 1.0;
  localparam int          MS_CYCLES      = int'(MS_TIME * CLK_MHZ * 1000.0);
  localparam int          REG_COUNT      = 12;
  // Warning bit positions in the status output
  localparam int          WB_IOUT        = 0;
  localparam int          WB_IIN         = 1;
  localparam int          WB_OT          = 2;
  localparam int          WB_VIN_UV      = 3;
endpackage : clcb_pkg

//--- src/clcb_cfg_if.sv
`timescale 1ns/100ps
interface clcb_cfg_if;
  logic [7:0]  ot_act;
  logic [7:0]  vin_act;
  logic [15:0] wait_ms;
  logic [15:0] ramp_ms;
  modport bank (output ot_act, vin_act, wait_ms, ramp_ms);
  modport ctrl (input ot_act, vin_act, wait_ms, ramp_ms);
endinterface : clcb_cfg_if

//--- src/clcb_pgood.sv
`timescale 1ns/100ps
module clcb_pgood
  import clcb_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic [15:0] vout_sense,
  input  wire logic [15:0] on_level,
  input  wire logic [15:0] off_level,
  output logic             pgood
);
  typedef struct packed {logic pg;} clcb_pg_s;
  clcb_pg_s st_ff;
  clcb_pg_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (vout_sense > on_level) begin
      nxt_st.pg = 1'b1;
    end else if (vout_sense < off_level) begin
      nxt_st.pg = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end
  assign pgood = st_ff.pg;

  property p_pg_hys;
    @(posedge mclk) disable iff (!rst_n)
      (ce && vout_sense < off_level) |=> !pgood;
  endproperty
  a_pg_hys: assert property (p_pg_hys) else $error("pgood stayed high below off level");
endmodule : clcb_pgood

//--- src/clcb_seq.sv
`timescale 1ns/100ps
module clcb_seq
  import clcb_pkg::*;
#(
  parameter int MS_CNT = MS_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        on_req,
  input  wire logic        ot_fault,
  input  wire logic        vin_fault,
  input  wire logic        other_fault,
  clcb_cfg_if.ctrl         cfg,
  output logic             out_en,
  output logic             ramping
);
  typedef enum logic [3:0] {
    S_OFF  = 4'b0001,
    S_WAIT = 4'b0010,
    S_RAMP = 4'b0100,
    S_ON   = 4'b1000
  } clcb_st_e;
  typedef struct packed {
    clcb_st_e    st;
    logic [31:0] tick;
    logic [10:0] ms;
    logic        vin_hold;
  } clcb_seq_s;
  clcb_seq_s st_ff;
  clcb_seq_s nxt_st;
  logic ot_block;
  logic vin_block;
  logic ms_done;

  // Output-off actions hold while fault persists; 00h ignores the fault
  assign ot_block  = ot_fault && (cfg.ot_act != ACT_IGNORE);
  assign vin_block = (vin_fault && (cfg.vin_act != ACT_IGNORE)) || st_ff.vin_hold;
  assign ms_done   = (st_ff.tick == 32'(MS_CNT - 1));

  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = ms_done ? 32'h0 : st_ff.tick + 32'h1;
    if (ms_done) begin
      nxt_st.ms = st_ff.ms + 11'h1;
    end
    // Latch under B8h until fault clears; then restart
    if (cfg.vin_act == ACT_VIN_LATCH) begin
      nxt_st.vin_hold = vin_fault;
    end else begin
      nxt_st.vin_hold = 1'b0;
    end
    if (!on_req || other_fault || ot_block || vin_block) begin
      // Retry forever: return to off and restart once clear
      nxt_st.st   = S_OFF;
      nxt_st.tick = 32'h0;
      nxt_st.ms   = 11'h0;
    end else begin
      case (st_ff.st)
        S_OFF: begin
          nxt_st.st   = S_WAIT;
          nxt_st.tick = 32'h0;
          nxt_st.ms   = 11'h0;
        end
        S_WAIT: begin
          if (st_ff.ms >= cfg.wait_ms[10:0]) begin
            nxt_st.st   = S_RAMP;
            nxt_st.tick = 32'h0;
            nxt_st.ms   = 11'h0;
          end
        end
        S_RAMP: begin
          if (st_ff.ms >= cfg.ramp_ms[10:0]) begin
            nxt_st.st = S_ON;
          end
        end
        S_ON: nxt_st.st = S_ON;
        default: nxt_st.st = S_OFF;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_ff    <= '0;
      st_ff.st <= S_OFF;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end
  assign out_en  = (st_ff.st == S_RAMP) || (st_ff.st == S_ON);
  assign ramping = (st_ff.st == S_RAMP);

  property p_ot_off;
    @(posedge mclk) disable iff (!rst_n)
      (ce && ot_fault && cfg.ot_act == ACT_OT_RETRY) |=> !out_en;
  endproperty
  a_ot_off: assert property (p_ot_off) else $error("output on during OT fault");

  sequence s_ot_clear;
    ce && !ot_fault && on_req && !other_fault && !vin_block && st_ff.st == S_OFF;
  endsequence
  property p_ot_retry;
    @(posedge mclk) disable iff (!rst_n)
      s_ot_clear |=> (!ce || st_ff.st == S_WAIT || !on_req);
  endproperty
  a_ot_retry: assert property (p_ot_retry) else $error("no restart after OT cleared");

  property p_vin_off;
    @(posedge mclk) disable iff (!rst_n)
      (ce && vin_fault && cfg.vin_act == ACT_VIN_LATCH) |=> (!out_en [*2]);
  endproperty
  a_vin_off: assert property (p_vin_off) else $error("output on during VIN OV fault");
endmodule : clcb_seq

//--- testbench/clcb_host_model.sv
`timescale 1ns/100ps
module clcb_host_model (
  input  wire logic        mclk,
  output logic             cmd_wr,
  output logic             cmd_rd,
  output logic [7:0]       cmd_addr,
  output logic [15:0]      cmd_wdata,
  input  wire logic        cmd_ack,
  input  wire logic        cmd_nack,
  input  wire logic [15:0] cmd_rdata
);
  initial begin
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_addr = 8'h00;
    cmd_wdata = 16'h0000;
  end
  // Strobe lasts one cycle; answer is picked up at the falling edge half a cycle after the taking edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [15:0] d,
                      output logic [1:0] an, output logic [15:0] rd);
    @(negedge mclk);
    cmd_wr = wr;
    cmd_rd = ~wr;
    cmd_addr = a;
    cmd_wdata = d;
    @(negedge mclk);
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    // Idle data lines toggle so a stale word is never mistaken for a live one
    cmd_wdata = ~d;
    an = {cmd_ack, cmd_nack};
    rd = cmd_rdata;
  endtask : xfer
endmodule : clcb_host_model

//--- testbench/clcb_top_tb.sv
`timescale 1ns/100ps
module clcb_top_tb;
  import clcb_pkg::*;
  logic        mclk, rst_n, ce, on_req, other_fault;
  logic        cmd_wr, cmd_rd, cmd_ack, cmd_nack;
  logic [7:0]  cmd_addr;
  logic [15:0] cmd_wdata, cmd_rdata, vout_sense, rd;
  logic [10:0] iout_meas, iin_meas, temp_meas, vin_meas;
  logic        out_en, pgood, ot_flt_stat, vin_flt_stat;
  logic [3:0]  warn_stat;
  logic [1:0]  an;
  int          failures, n_tests, cyc;

  clcb_top #(.MS_CNT(4)) u_clcb_top (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .on_req(on_req),
    .other_fault(other_fault), .iout_meas(iout_meas), .iin_meas(iin_meas),
    .temp_meas(temp_meas), .vin_meas(vin_meas), .vout_sense(vout_sense),
    .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack), .cmd_nack(cmd_nack), .out_en(out_en),
    .pgood(pgood), .warn_stat(warn_stat), .ot_flt_stat(ot_flt_stat),
    .vin_flt_stat(vin_flt_stat));
  clcb_host_model u_clcb_host_model (
    .mclk(mclk), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_ack(cmd_ack), .cmd_nack(cmd_nack),
    .cmd_rdata(cmd_rdata));

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // e is the expected {ack, nack} pair
  task automatic cmd(input logic wr, input logic [7:0] a, input logic [15:0] d,
                     input logic [1:0] e);
    u_clcb_host_model.xfer(wr, a, d, an, rd);
    check("ack nack", {14'h0, an}, {14'h0, e});
  endtask : cmd
  task automatic wait_en(input logic v);
    int i;
    for (i = 0; i < 200 && out_en !== v; i++) @(negedge mclk);
    check("out_en", {15'h0, out_en}, {15'h0, v});
  endtask : wait_en
  task automatic hold_off(input int n);
    repeat (n) @(negedge mclk);
    check("out_en held", {15'h0, out_en}, 16'h0000);
  endtask : hold_off

  task automatic t_defaults;
    logic [7:0]  a[12] = '{ADDR_IOUT_OCW, ADDR_OT_FLT, ADDR_OT_ACT, ADDR_OT_WRN,
      ADDR_VIN_OVF, ADDR_VIN_ACT, ADDR_VIN_UVW, ADDR_IIN_OCW, ADDR_PG_ON, ADDR_PG_OFF,
      ADDR_TON_WAIT, ADDR_TON_RAMP};
    logic [15:0] e[12] = '{16'hF868, 16'h007D, 16'h00F9, 16'h0069, 16'hF81E, 16'h00B8,
      16'hF812, 16'hF80A, 16'h0114, 16'h0105, 16'h0000, 16'h0005};
    for (int i = 0; i < 12; i++) begin
      cmd(1'b0, a[i], 16'h0000, 2'b10);
      check("default", rd, e[i]);
    end
  endtask : t_defaults

  task automatic t_actions;
    logic [7:0] ot[9] = '{8'h00, 8'h16, 8'h22, 8'h36, 8'hC0, 8'hD6, 8'hE2, 8'hF6, 8'hF9};
    logic [7:0] vi[9] = '{8'h00, 8'h16, 8'h22, 8'h36, 8'hC0, 8'hD6, 8'hE2, 8'hF6, 8'hB8};
    for (int i = 0; i < 9; i++) begin
      cmd(1'b1, ADDR_OT_ACT, {8'h00, ot[i]}, 2'b10);
      cmd(1'b1, ADDR_VIN_ACT, {8'h00, vi[i]}, 2'b10);
    end
    cmd(1'b1, ADDR_OT_ACT, 16'h00B8, 2'b01);
    cmd(1'b1, ADDR_VIN_ACT, 16'h00F9, 2'b01);
    cmd(1'b0, ADDR_OT_ACT, 16'h0000, 2'b10);
    check("ot action kept", rd, 16'h00F9);
    cmd(1'b0, ADDR_VIN_ACT, 16'h0000, 2'b10);
    check("vin action kept", rd, 16'h00B8);
  endtask : t_actions

  task automatic t_ot;
    on_req = 1'b1;
    wait_en(1'b1);
    temp_meas = 11'd124;
    repeat (10) @(negedge mclk);
    check("below ot", {15'h0, out_en}, 16'h0001);
    repeat (3) begin
      temp_meas = 11'd125;
      wait_en(1'b0);
      check("ot flag", {15'h0, ot_flt_stat}, 16'h0001);
      hold_off(30);
      temp_meas = 11'd25;
      wait_en(1'b1);
    end
    other_fault = 1'b1;
    wait_en(1'b0);
    other_fault = 1'b0;
    wait_en(1'b1);
  endtask : t_ot

  task automatic t_vin;
    vin_meas = 11'd30;
    wait_en(1'b0);
    hold_off(100);
    vin_meas = 11'd20;
    wait_en(1'b1);
    cmd(1'b1, ADDR_VIN_ACT, 16'h0000, 2'b10);
    vin_meas = 11'd30;
    repeat (20) @(negedge mclk);
    check("ignored fault", {15'h0, out_en}, 16'h0001);
    vin_meas = 11'd20;
    cmd(1'b1, ADDR_VIN_ACT, 16'h00B8, 2'b10);
  endtask : t_vin

  task automatic t_pgood;
    logic [15:0] v[4] = '{16'h0115, 16'h0106, 16'h0104, 16'h0110};
    logic        p[4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    for (int i = 0; i < 4; i++) begin
      vout_sense = v[i];
      repeat (4) @(negedge mclk);
      check("pgood", {15'h0, pgood}, {15'h0, p[i]});
    end
  endtask : t_pgood

  task automatic t_warn;
    iout_meas = 11'd104;
    iin_meas = 11'd10;
    temp_meas = 11'd105;
    vin_meas = 11'd17;
    repeat (3) @(negedge mclk);
    check("warn", {12'h0, warn_stat}, 16'h000F);
    check("out kept", {15'h0, out_en}, 16'h0001);
    iout_meas = 11'd103;
    iin_meas = 11'd9;
    temp_meas = 11'd104;
    vin_meas = 11'd18;
    repeat (3) @(negedge mclk);
    check("warn clear", {12'h0, warn_stat}, 16'h0000);
  endtask : t_warn

  // Enable low must hide a fault and a warning until it returns
  task automatic t_ce;
    ce = 1'b0;
    temp_meas = 11'd125;
    repeat (5) @(negedge mclk);
    check("frozen", {15'h0, out_en}, 16'h0001);
    check("warn frozen", {12'h0, warn_stat}, 16'h0000);
    ce = 1'b1;
    wait_en(1'b0);
    temp_meas = 11'd25;
    wait_en(1'b1);
  endtask : t_ce

  task automatic t_range;
    logic [7:0]  a[7] = '{ADDR_IOUT_OCW, ADDR_IIN_OCW, ADDR_OT_FLT, ADDR_VIN_OVF,
      ADDR_VIN_UVW, ADDR_PG_ON, ADDR_TON_RAMP};
    logic [15:0] g[7] = '{16'hF8FE, 16'hF800, 16'h0096, 16'hF802, 16'hF8A0, 16'h007B,
      16'h007F};
    logic [15:0] b[7] = '{16'hF8FF, 16'hF8FF, 16'h0097, 16'hF801, 16'hF8A1, 16'h007A,
      16'h0080};
    for (int i = 0; i < 7; i++) begin
      cmd(1'b1, a[i], g[i], 2'b10);
      cmd(1'b1, a[i], b[i], 2'b01);
      cmd(1'b0, a[i], 16'h0000, 2'b10);
      check("range kept", rd, g[i]);
    end
    cmd(1'b1, 8'h4B, 16'h0001, 2'b01);
    cmd(1'b1, ADDR_PG_OFF, 16'h1C00, 2'b10);
  endtask : t_range

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Whole sequence needs a few hundred cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      tally_and_finish();
    end
  end
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    on_req = 1'b0;
    other_fault = 1'b0;
    iout_meas = 11'd0;
    iin_meas = 11'd0;
    temp_meas = 11'd25;
    vin_meas = 11'd20;
    vout_sense = 16'h0000;
    repeat (6) @(negedge mclk);
    rst_n = 1'b1;
    t_defaults();
    t_actions();
    t_ot();
    t_vin();
    t_pgood();
    t_warn();
    t_ce();
    t_range();
    tally_and_finish();
  end
endmodule : clcb_top_tb
